// [design/atsu_cfg.svh]
// Offsets, field positions, reset values and timing of the stamp unit
`ifndef ATSU_CFG_SVH
`define ATSU_CFG_SVH
// Register indices; byte address is four times the index
`define ATSU_IDX_RATE      18'h04E20
`define ATSU_IDX_CMD       18'h0B798
`define ATSU_IDX_CAPS      18'h0B799
`define ATSU_IDX_TIME      18'h0B7B6
`define ATSU_IDX_DATE      18'h0B7B7
`define ATSU_IDX_TMO       18'h0B7C5
`define ATSU_IDX_OVS       18'h30DBB
`define ATSU_IDX_STAT      18'h0B7F0
// Command word fields
`define ATSU_CLEAR_BIT     0
`define ATSU_MODE_LSB      1
`define ATSU_SRC_LSB       8
`define ATSU_AUX_BIT       12
`define ATSU_FEAT_BIT      16
`define ATSU_CLEAR_ONLY    32'h00000001
// Status fields
`define ATSU_ST_WAIT_BIT   0
`define ATSU_ST_TMO_BIT    1
`define ATSU_ST_OVF_BIT    2
`define ATSU_ST_LVL_LSB    16
// Widths
`define ATSU_STAMP_W       64
`define ATSU_CNT_W         56
`define ATSU_AUX_W         8
`define ATSU_LOW_W         32
`define ATSU_FIFO_DEPTH    16
// Reset values
`define ATSU_CAPS_VAL      32'h00011706
`define ATSU_TMO_RST       32'h000003E8
`define ATSU_TIME_RST      32'h00000000
`define ATSU_DATE_RST      32'h00000000
// Timing
`define ATSU_CLK_PERIOD_NS 100
`define ATSU_MS_NS         1000000
`define ATSU_CYC_PER_MS    (`ATSU_MS_NS / `ATSU_CLK_PERIOD_NS)
`endif

// [design/atsu_pkg.sv]
// Types shared by the stamp unit
package atsu_pkg;
  typedef enum logic [0:0] {
    ATSU_IDLE = 1'b0,
    ATSU_WAIT = 1'b1
  } atsu_state_type;
  typedef enum logic [1:0] {
    ATSU_MODE_OFF   = 2'b00,
    ATSU_MODE_STD   = 2'b01,
    ATSU_MODE_START = 2'b10
  } atsu_mode_type;
  typedef enum logic [2:0] {
    ATSU_SRC_INT = 3'b001,
    ATSU_SRC_POS = 3'b010,
    ATSU_SRC_NEG = 3'b100
  } atsu_src_type;
endpackage

// [design/atsu_top.sv]
// Timestamp unit: sample counter, capture, stamp FIFO and registers
`timescale 1ns/100ps
`include "atsu_cfg.svh"
// Overview of operation
// R1: Wide counter advances once per sample
// R2: Trigger copies counter value into stamp FIFO
// R3: Gated acquisition stamps gate open and close
// R4: Every stored stamp is 64 bits wide
// R5: Stamp equals samples since last clear
// R6: Mode zero disables stamp generation
// R7: Clear command zeroes the counter
// R8: Standard mode clears only on command
// R9: Start-clear mode zeroes counter at card start
// R10: Command groups OR-ed, decoded separately
// R11: Internal source counts full width on samples
// R12: Rising reference edges count upper part
// R13: Falling reference edges count upper part
// R14: Aux inputs sampled into upper byte
// R15: Aux off fills upper byte with zeros
// R16: First A sample extra stamp in dual timebase
// R17: Clear acts only with clock generation running
// R18: Counter runs at non-interlaced rate, max 125MS/s
// R19: Millisecond timeout bounds wait for reference edge
// R20: Time register holds hours, minutes, seconds
// R21: Date register holds year, month, day
// R22: Capability register returns supported modes bitmap
// R23: FIFO hands out stamps in capture order
module atsu_top #(
  parameter int          LOW_W      = `ATSU_LOW_W,
  parameter int          FIFO_DEPTH = `ATSU_FIFO_DEPTH,
  parameter int          CYC_PER_MS = `ATSU_CYC_PER_MS,
  parameter logic [31:0] CAPS       = `ATSU_CAPS_VAL
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // Register port
  input  wire logic [19:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Acquisition control
  input  wire logic        SAMPLE_TICK,
  input  wire logic        TRIGGER,
  input  wire logic        GATED_MODE,
  input  wire logic        GATE,
  input  wire logic        DUAL_TB_MODE,
  input  wire logic        FIRST_A_SAMPLE,
  input  wire logic        CARD_START,
  input  wire logic        CLOCK_GEN_ACTIVE,
  input  wire logic [31:0] SAMPLE_RATE,
  input  wire logic [31:0] OVERSAMPLING,
  // External pins
  input  wire logic        REF_CLK_PIN,
  input  wire logic [7:0]  AUX_IN_PIN,
  // Stamp readout
  output logic             STAMP_VALID,
  output logic      [63:0] STAMP_DATA,
  input  wire logic        STAMP_READY
);

  localparam int AW   = $clog2(FIFO_DEPTH);
  localparam int CW   = `ATSU_CNT_W;
  localparam int SW   = `ATSU_STAMP_W;
  localparam int XW   = `ATSU_AUX_W;
  localparam int PINS = XW + 1;
  localparam logic [AW:0] FULL = (AW + 1)'(FIFO_DEPTH);
  localparam logic [31:0] MS_LAST = 32'(CYC_PER_MS - 1);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk_depth
    $error("FIFO_DEPTH must be a power of two from 2 to 128");
  end
  if (LOW_W < 1 || LOW_W >= CW) begin : g_chk_low
    $error("LOW_W must lie between 1 and counter width minus one");
  end
  if (CYC_PER_MS < 1) begin : g_chk_ms
    $error("CYC_PER_MS must be at least one");
  end

  function automatic logic hit(input logic [19:0] addr,
                               input logic [17:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  // Pin synchronisers
  logic [PINS-1:0] s1_ff;
  logic [PINS-1:0] s2_ff;
  logic [PINS-1:0] s3_ff;
  logic [PINS-1:0] stable_ff;
  logic            ref_prev_ff;
  logic            gate_prev_ff;
  logic [PINS-1:0] nxt_s1;
  logic [PINS-1:0] nxt_s2;
  logic [PINS-1:0] nxt_s3;
  logic [PINS-1:0] nxt_stable;
  logic            nxt_ref_prev;
  logic            nxt_gate_prev;

  always_comb begin
    nxt_s1        = {REF_CLK_PIN, AUX_IN_PIN};
    nxt_s2        = s1_ff;
    nxt_s3        = s2_ff;
    nxt_stable    = stable_ff;
    nxt_ref_prev  = stable_ff[XW];
    nxt_gate_prev = GATE;
    for (int i = 0; i < PINS; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_stable[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_ff        <= '0;
      s2_ff        <= '0;
      s3_ff        <= '0;
      stable_ff    <= '0;
      ref_prev_ff  <= 1'b0;
      gate_prev_ff <= 1'b0;
    end else begin
      s1_ff        <= nxt_s1;
      s2_ff        <= nxt_s2;
      s3_ff        <= nxt_s3;
      stable_ff    <= nxt_stable;
      ref_prev_ff  <= nxt_ref_prev;
      gate_prev_ff <= nxt_gate_prev;
    end
  end

  logic ref_rise;
  logic ref_fall;
  assign ref_rise = stable_ff[XW] & ~ref_prev_ff;
  assign ref_fall = ~stable_ff[XW] & ref_prev_ff;

  // Configuration registers
  logic [1:0]  mode_ff;
  logic [2:0]  src_ff;
  logic        aux_ff;
  logic        feat_ff;
  logic [31:0] time_ff;
  logic [31:0] date_ff;
  logic [31:0] tmo_ff;
  logic [1:0]  nxt_mode;
  logic [2:0]  nxt_src;
  logic        nxt_aux;
  logic        nxt_feat;
  logic [31:0] nxt_time;
  logic [31:0] nxt_date;
  logic [31:0] nxt_tmo;
  logic        wr_cmd;
  logic        wr_stat;
  logic        clear_cmd;

  assign wr_cmd  = REG_WR && hit(REG_ADDR, `ATSU_IDX_CMD);
  assign wr_stat = REG_WR && hit(REG_ADDR, `ATSU_IDX_STAT);
  // R7: clear command decode
  // R17: gated by clock generation
  assign clear_cmd = wr_cmd && REG_WDATA[`ATSU_CLEAR_BIT] &&
                     CLOCK_GEN_ACTIVE;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_src  = src_ff;
    nxt_aux  = aux_ff;
    nxt_feat = feat_ff;
    nxt_time = time_ff;
    nxt_date = date_ff;
    nxt_tmo  = tmo_ff;
    // R10: groups decoded separately
    if (wr_cmd && REG_WDATA != `ATSU_CLEAR_ONLY) begin
      nxt_mode = REG_WDATA[`ATSU_MODE_LSB +: 2];
      nxt_src  = REG_WDATA[`ATSU_SRC_LSB +: 3];
      nxt_aux  = REG_WDATA[`ATSU_AUX_BIT];
      nxt_feat = REG_WDATA[`ATSU_FEAT_BIT];
    end
    // R20: time fields stored whole
    if (REG_WR && hit(REG_ADDR, `ATSU_IDX_TIME)) begin
      nxt_time = REG_WDATA;
    end
    // R21: date fields stored whole
    if (REG_WR && hit(REG_ADDR, `ATSU_IDX_DATE)) begin
      nxt_date = REG_WDATA;
    end
    if (REG_WR && hit(REG_ADDR, `ATSU_IDX_TMO)) begin
      nxt_tmo = REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_ff <= 2'h0;
      src_ff  <= 3'h0;
      aux_ff  <= 1'b0;
      feat_ff <= 1'b0;
      time_ff <= `ATSU_TIME_RST;
      date_ff <= `ATSU_DATE_RST;
      tmo_ff  <= `ATSU_TMO_RST;
    end else begin
      mode_ff <= nxt_mode;
      src_ff  <= nxt_src;
      aux_ff  <= nxt_aux;
      feat_ff <= nxt_feat;
      time_ff <= nxt_time;
      date_ff <= nxt_date;
      tmo_ff  <= nxt_tmo;
    end
  end

  logic run;
  logic split;
  logic ref_edge;
  // R6: only the standard and start-clear mode codes run
  assign run = (mode_ff == atsu_pkg::ATSU_MODE_STD) ||
               (mode_ff == atsu_pkg::ATSU_MODE_START);
  assign split = (src_ff == atsu_pkg::ATSU_SRC_POS) ||
                 (src_ff == atsu_pkg::ATSU_SRC_NEG);
  // R12: rising edge selected
  // R13: falling edge selected
  assign ref_edge = (src_ff == atsu_pkg::ATSU_SRC_POS) ? ref_rise :
                                                         ref_fall;

  // Counter and reference wait
  atsu_pkg::atsu_state_type st_ff;
  atsu_pkg::atsu_state_type nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [31:0]   pre_ff;
  logic [31:0]   left_ff;
  logic          tmo_flag_ff;
  logic [CW-1:0] nxt_cnt;
  logic [31:0]   nxt_pre;
  logic [31:0]   nxt_left;
  logic          nxt_tmo_flag;

  always_comb begin
    nxt_st       = st_ff;
    nxt_cnt      = cnt_ff;
    nxt_pre      = pre_ff;
    nxt_left     = left_ff;
    nxt_tmo_flag = tmo_flag_ff;
    if (wr_stat && REG_WDATA[`ATSU_ST_TMO_BIT]) begin
      nxt_tmo_flag = 1'b0;
    end
    if (run) begin
      if (split && ref_edge) begin
        // R12: upper part counts edges
        nxt_cnt[CW-1:LOW_W] = cnt_ff[CW-1:LOW_W] + 1'b1;
        nxt_cnt[LOW_W-1:0]  = '0;
      end else if (SAMPLE_TICK) begin
        // R18: one step per base sample
        if (split) begin
          // R13: lower part counts samples
          nxt_cnt[LOW_W-1:0] = cnt_ff[LOW_W-1:0] + 1'b1;
        end else begin
          // R11: full width on samples
          // R1: advance once per sample
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      // R9: zero at card start in start-clear mode only
      if (mode_ff == atsu_pkg::ATSU_MODE_START && CARD_START) begin
        nxt_cnt = '0;
      end
    end
    case (st_ff)
      atsu_pkg::ATSU_IDLE: begin
        // R8: explicit clear in any mode
        if (clear_cmd) begin
          if (split) begin
            nxt_st   = atsu_pkg::ATSU_WAIT;
            nxt_pre  = 32'h00000000;
            nxt_left = tmo_ff;
          end else begin
            nxt_cnt = '0;
          end
        end
      end
      atsu_pkg::ATSU_WAIT: begin
        if (ref_edge) begin
          // R7: both parts zeroed on edge
          nxt_cnt = '0;
          nxt_st  = atsu_pkg::ATSU_IDLE;
        end else if (left_ff == 32'h00000000) begin
          // R19: give up after timeout
          nxt_tmo_flag = 1'b1;
          nxt_st       = atsu_pkg::ATSU_IDLE;
        end else if (pre_ff == MS_LAST) begin
          nxt_pre  = 32'h00000000;
          nxt_left = left_ff - 32'h00000001;
        end else begin
          nxt_pre = pre_ff + 32'h00000001;
        end
      end
      default: begin
        nxt_st = atsu_pkg::ATSU_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff       <= atsu_pkg::ATSU_IDLE;
      cnt_ff      <= '0;
      pre_ff      <= 32'h00000000;
      left_ff     <= 32'h00000000;
      tmo_flag_ff <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      cnt_ff      <= nxt_cnt;
      pre_ff      <= nxt_pre;
      left_ff     <= nxt_left;
      tmo_flag_ff <= nxt_tmo_flag;
    end
  end

  // Capture events
  logic          gate_edge;
  logic          event_hit;
  logic [XW-1:0] aux_byte;
  logic [SW-1:0] stamp;
  assign gate_edge = GATE ^ gate_prev_ff;
  // R2: trigger stamps
  // R3: gate open and close stamps
  // R16: first A sample stamp
  // R6: nothing stored when off
  assign event_hit = run &&
                     ((!GATED_MODE && TRIGGER) ||
                      (GATED_MODE && gate_edge) ||
                      (feat_ff && DUAL_TB_MODE && FIRST_A_SAMPLE));
  // R14: aux inputs in upper byte
  // R15: zeros when aux capture off
  assign aux_byte = aux_ff ? stable_ff[XW-1:0] : '0;
  // R4: fixed 64-bit stamp
  // R5: stamp is present count
  assign stamp = {aux_byte, cnt_ff};

  // Stamp FIFO
  logic [SW-1:0] mem [FIFO_DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   lvl_ff;
  logic          ovf_ff;
  logic          out_v_ff;
  logic [SW-1:0] out_d_ff;
  logic [AW-1:0] nxt_wp;
  logic [AW-1:0] nxt_rp;
  logic [AW:0]   nxt_lvl;
  logic          nxt_ovf;
  logic          nxt_out_v;
  logic [SW-1:0] nxt_out_d;
  logic          push;
  logic          pop;

  assign push = event_hit && (lvl_ff != FULL);
  assign pop  = (lvl_ff != '0) && (!out_v_ff || STAMP_READY);

  always_comb begin
    nxt_wp    = wp_ff;
    nxt_rp    = rp_ff;
    nxt_lvl   = lvl_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_ovf   = ovf_ff;
    nxt_out_v = out_v_ff;
    nxt_out_d = out_d_ff;
    if (wr_stat && REG_WDATA[`ATSU_ST_OVF_BIT]) begin
      nxt_ovf = 1'b0;
    end
    if (event_hit && !push) begin
      nxt_ovf = 1'b1;
    end
    if (push) begin
      nxt_wp = wp_ff + 1'b1;
    end
    // R23: oldest entry goes out first
    if (pop) begin
      nxt_rp    = rp_ff + 1'b1;
      nxt_out_v = 1'b1;
      nxt_out_d = mem[rp_ff];
    end else if (STAMP_READY) begin
      nxt_out_v = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem[wp_ff] <= stamp;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_ff    <= '0;
      rp_ff    <= '0;
      lvl_ff   <= '0;
      ovf_ff   <= 1'b0;
      out_v_ff <= 1'b0;
      out_d_ff <= '0;
    end else begin
      wp_ff    <= nxt_wp;
      rp_ff    <= nxt_rp;
      lvl_ff   <= nxt_lvl;
      ovf_ff   <= nxt_ovf;
      out_v_ff <= nxt_out_v;
      out_d_ff <= nxt_out_d;
    end
  end

  // Register read
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic [31:0] cmd_word;
  logic [31:0] stat_word;

  always_comb begin
    cmd_word = 32'h00000000;
    cmd_word[`ATSU_MODE_LSB +: 2] = mode_ff;
    cmd_word[`ATSU_SRC_LSB +: 3]  = src_ff;
    cmd_word[`ATSU_AUX_BIT]       = aux_ff;
    cmd_word[`ATSU_FEAT_BIT]      = feat_ff;
    stat_word = 32'h00000000;
    stat_word[`ATSU_ST_WAIT_BIT]    = (st_ff == atsu_pkg::ATSU_WAIT);
    stat_word[`ATSU_ST_TMO_BIT]     = tmo_flag_ff;
    stat_word[`ATSU_ST_OVF_BIT]     = ovf_ff;
    stat_word[`ATSU_ST_LVL_LSB +: 8] = 8'(lvl_ff);
    nxt_rd = 32'h00000000;
    if (REG_RD) begin
      if (hit(REG_ADDR, `ATSU_IDX_CMD)) begin
        nxt_rd = cmd_word;
      end else if (hit(REG_ADDR, `ATSU_IDX_CAPS)) begin
        // R22: supported modes bitmap
        nxt_rd = CAPS;
      end else if (hit(REG_ADDR, `ATSU_IDX_TIME)) begin
        nxt_rd = {8'h00, time_ff[23:0]};
      end else if (hit(REG_ADDR, `ATSU_IDX_DATE)) begin
        nxt_rd = date_ff;
      end else if (hit(REG_ADDR, `ATSU_IDX_TMO)) begin
        nxt_rd = tmo_ff;
      end else if (hit(REG_ADDR, `ATSU_IDX_RATE)) begin
        nxt_rd = SAMPLE_RATE;
      end else if (hit(REG_ADDR, `ATSU_IDX_OVS)) begin
        nxt_rd = OVERSAMPLING;
      end else if (hit(REG_ADDR, `ATSU_IDX_STAT)) begin
        nxt_rd = stat_word;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_ff <= 32'h00000000;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign REG_RDATA   = rd_ff;
  assign STAMP_VALID = out_v_ff;
  assign STAMP_DATA  = out_d_ff;

endmodule

// [verif/atsu_acq_model.sv]
// Card acquisition control driving the stamp unit
`timescale 1ns/100ps
module atsu_acq_model (
  // Clock
  input  wire logic clk,
  // Events
  output logic      tick,
  output logic      trig,
  output logic      gate,
  output logic      first_a,
  output logic      start,
  // Pin and readout
  output logic      ref_pin,
  output logic      ready
);
  logic [1:0] pls = 2'b00;
  logic [2:0] cyc = 3'h0;
  assign first_a = pls[0];
  assign start   = pls[1];
  initial begin
    tick    = 1'b0;
    trig    = 1'b0;
    gate    = 1'b0;
    ref_pin = 1'b0;
    ready   = 1'b0;
  end
  // Readout stalls three cycles in eight
  always @(posedge clk) begin
    cyc   <= cyc + 3'h1;
    ready <= cyc > 3'h2;
  end
  task automatic run(input int k, input logic t);
    repeat (k) begin
      @(posedge clk);
      tick <= 1'b1;
      trig <= t;
    end
    @(posedge clk);
    tick <= 1'b0;
    trig <= 1'b0;
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    pls[s] <= 1'b1;
    @(posedge clk);
    pls[s] <= 1'b0;
  endtask
  task automatic gate_to(input logic v);
    @(posedge clk);
    gate <= v;
    @(posedge clk);
  endtask
  task automatic refp;
    @(posedge clk);
    ref_pin <= 1'b1;
    repeat (8) @(posedge clk);
    ref_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [verif/atsu_asserts.sv]
// Port checks of the stamp unit
`timescale 1ns/100ps
`include "atsu_cfg.svh"
module atsu_chk #(
  parameter logic [31:0] CAPS = `ATSU_CAPS_VAL
) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  // Register port
  input wire logic [19:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Events
  input wire logic        TRIGGER,
  input wire logic        GATED_MODE,
  input wire logic        GATE,
  input wire logic [31:0] SAMPLE_RATE,
  // Stamp readout
  input wire logic        STAMP_VALID,
  input wire logic [63:0] STAMP_DATA,
  input wire logic        STAMP_READY
);
  localparam logic [19:0] addr_cmd  = {`ATSU_IDX_CMD, 2'b00};
  localparam logic [19:0] addr_caps = {`ATSU_IDX_CAPS, 2'b00};
  localparam logic [19:0] addr_rate = {`ATSU_IDX_RATE, 2'b00};
  localparam logic [19:0] addr_tmo  = {`ATSU_IDX_TMO, 2'b00};
  logic run_ff;
  logic nxt_run;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  // Mirror of the programmed mode
  always_comb begin
    nxt_run = run_ff;
    if (REG_WR && REG_ADDR == addr_cmd && REG_WDATA != `ATSU_CLEAR_ONLY) begin
      nxt_run = ^REG_WDATA[2:1];
    end
  end
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end
  sequence s_tmo_wr;
    REG_WR && REG_ADDR == addr_tmo;
  endsequence
  sequence s_tmo_rd;
    REG_RD && REG_ADDR == addr_tmo;
  endsequence
  sequence s_shown;
    ##[2:4] STAMP_VALID;
  endsequence
  property p_rd_idle;
    !REG_RD |=> REG_RDATA == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_caps;
    REG_RD && REG_ADDR == addr_caps |=> REG_RDATA == CAPS;
  endproperty
  a_caps: assert property (p_caps)
    else $error("capability word wrong");
  property p_rate;
    REG_RD && REG_ADDR == addr_rate |=> REG_RDATA == $past(SAMPLE_RATE);
  endproperty
  a_rate: assert property (p_rate)
    else $error("sample rate readback wrong");
  property p_tmo;
    s_tmo_wr ##1 s_tmo_rd |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout readback wrong");
  property p_hold;
    STAMP_VALID && !STAMP_READY |=> STAMP_VALID && $stable(STAMP_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stamp dropped while stalled");
  property p_trig;
    run_ff && !GATED_MODE && TRIGGER && !STAMP_VALID |-> s_shown;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger made no stamp");
  property p_gate;
    run_ff && GATED_MODE && $changed(GATE) && !STAMP_VALID |-> s_shown;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate edge made no stamp");
  property p_off;
    (!run_ff && !STAMP_VALID) [*4] |=> !STAMP_VALID;
  endproperty
  a_off: assert property (p_off)
    else $error("stamp while disabled");
endmodule
bind atsu_top atsu_chk #(.CAPS(CAPS)) u_chk (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .TRIGGER(TRIGGER), .GATED_MODE(GATED_MODE),
  .GATE(GATE), .SAMPLE_RATE(SAMPLE_RATE), .STAMP_VALID(STAMP_VALID),
  .STAMP_DATA(STAMP_DATA), .STAMP_READY(STAMP_READY)
);

// [verif/atsu_tb_top.sv]
// Self-checking bench of the stamp unit
`timescale 1ns/100ps
`include "atsu_cfg.svh"
module acquisition_timestamp_unit_tb_top;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic [19:0] addr   = 20'h00000;
  logic [31:0] wdata  = 32'h00000000;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        gated  = 1'b0;
  logic        dual   = 1'b0;
  logic        cgen   = 1'b1;
  logic [31:0] rate   = 32'h00000000;
  logic [31:0] ovs    = 32'h00000001;
  logic [7:0]  aux    = 8'h00;
  logic        aux_en = 1'b0;
  logic [55:0] c      = 56'h0;
  logic [31:0] rdata;
  logic [63:0] data;
  logic        valid, tick, trig, gate, first_a, start, ref_pin, ready;
  logic [63:0] expq[$];
  logic [31:0] srcs[2] = '{32'h00000202, 32'h00000402};
  int          n;
  int          cyc         = 0;
  int          mismatches  = 0;
  int          comparisons = 0;
  always #50 clk = ~clk;
  atsu_acq_model m (
    .clk(clk), .tick(tick), .trig(trig), .gate(gate), .first_a(first_a),
    .start(start), .ref_pin(ref_pin), .ready(ready)
  );
  atsu_top #(.CYC_PER_MS(10)) uut (
    .CLOCK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_TICK(tick),
    .TRIGGER(trig), .GATED_MODE(gated), .GATE(gate), .DUAL_TB_MODE(dual),
    .FIRST_A_SAMPLE(first_a), .CARD_START(start), .CLOCK_GEN_ACTIVE(cgen),
    .SAMPLE_RATE(rate), .OVERSAMPLING(ovs), .REF_CLK_PIN(ref_pin),
    .AUX_IN_PIN(aux), .STAMP_VALID(valid), .STAMP_DATA(data),
    .STAMP_READY(ready)
  );
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [17:0] i, input logic [31:0] d);
    @(posedge clk);
    addr  <= {i, 2'b00};
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [17:0] i, input logic [31:0] e);
    addr <= {i, 2'b00};
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk("register", 64'(e), 64'(rdata));
  endtask
  task automatic push(input logic [55:0] v);
    expq.push_back({aux_en ? aux : 8'h00, v});
  endtask
  task automatic tk(input int k, input logic t);
    if (t) begin
      for (int i = 0; i < k; i++) begin
        push(c + 56'(i));
      end
    end
    c += 56'(k);
    m.run(k, t);
  endtask
  task automatic drain;
    int w;
    w = 0;
    while (expq.size() != 0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    repeat (8) @(posedge clk);
    chk("pending", 64'h0, 64'(expq.size()));
  endtask
  always @(posedge clk) begin
    if (arst_n && valid === 1'b1 && ready === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("[FAIL] stamp expected none seen %h", data);
      end else begin
        chk("stamp", expq.pop_front(), data);
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(64));
    rate <= $urandom;
    aux  <= 8'($urandom);
    ovs  <= $urandom;
    n = $urandom_range(40, 1);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`ATSU_IDX_CAPS, `ATSU_CAPS_VAL);
    wr_reg(`ATSU_IDX_CAPS, 32'h00000000);
    rd_chk(`ATSU_IDX_CAPS, `ATSU_CAPS_VAL);
    rd_chk(`ATSU_IDX_TMO, `ATSU_TMO_RST);
    rd_chk(18'h00123, 32'h00000000);
    rd_chk(`ATSU_IDX_RATE, rate);
    rd_chk(`ATSU_IDX_OVS, ovs);
    wr_reg(`ATSU_IDX_TIME, 32'hFF173B2A);
    rd_chk(`ATSU_IDX_TIME, 32'h00173B2A);
    wr_reg(`ATSU_IDX_DATE, 32'h07E40C1F);
    rd_chk(`ATSU_IDX_DATE, 32'h07E40C1F);
    wr_reg(`ATSU_IDX_TMO, 32'h00000005);
    rd_chk(`ATSU_IDX_TMO, 32'h00000005);
    m.run(4, 1'b1);
    repeat (3) begin
      wr_reg(`ATSU_IDX_CMD, 32'h00000103);
      c = 56'h0;
      tk(n, 1'b0);
      tk(3, 1'b1);
      n = $urandom_range(40, 1);
    end
    cgen <= 1'b0;
    wr_reg(`ATSU_IDX_CMD, `ATSU_CLEAR_ONLY);
    tk(2, 1'b1);
    cgen <= 1'b1;
    m.pulse(1);
    tk(2, 1'b1);
    wr_reg(`ATSU_IDX_CMD, 32'h00000104);
    tk(5, 1'b0);
    m.pulse(1);
    c = 56'h0;
    aux <= 8'($urandom);
    tk(n, 1'b0);
    tk(2, 1'b1);
    wr_reg(`ATSU_IDX_CMD, 32'h00001102);
    aux_en = 1'b1;
    tk(2, 1'b1);
    wr_reg(`ATSU_IDX_CMD, 32'h00000102);
    aux_en = 1'b0;
    tk(2, 1'b1);
    drain();
    gated <= 1'b1;
    push(c);
    m.gate_to(1'b1);
    m.run(n, 1'b1);
    c += 56'(n);
    push(c);
    m.gate_to(1'b0);
    gated <= 1'b0;
    wr_reg(`ATSU_IDX_CMD, 32'h00010102);
    dual <= 1'b1;
    push(c);
    m.pulse(0);
    dual <= 1'b0;
    m.pulse(0);
    foreach (srcs[j]) begin
      wr_reg(`ATSU_IDX_CMD, srcs[j]);
      wr_reg(`ATSU_IDX_CMD, `ATSU_CLEAR_ONLY);
      m.refp();
      c = 56'h0;
      tk(n, 1'b0);
      m.refp();
      c = 56'h00000100000000;
      tk(2, 1'b1);
    end
    drain();
    wr_reg(`ATSU_IDX_TMO, 32'h00000002);
    wr_reg(`ATSU_IDX_CMD, 32'h00000203);
    rd_chk(`ATSU_IDX_STAT, 32'h00000001);
    repeat (30) @(posedge clk);
    rd_chk(`ATSU_IDX_STAT, 32'h00000002);
    drain();
    end_sim();
  end
endmodule
